// ==== include/cpi_pkg.sv ====
// Constants, register map and types for the channel pulse and surge control block
package cpi_pkg;
  // Register indices on the parallel register port
  localparam logic [5:0]  CPI_PULSE_ADDR    = 6'h0E;
  localparam logic [5:0]  CPI_LIMIT_ADDR    = 6'h0F;
  localparam logic [15:0] CPI_PULSE_RESET   = 16'h0000;
  localparam logic [15:0] CPI_LIMIT_RESET   = 16'h0088;
  localparam logic [15:0] CPI_PULSE_WMASK   = 16'h0FFF;
  localparam logic [15:0] CPI_LIMIT_WMASK   = 16'hFFFF;

  // Pulse register fields
  localparam int CPI_RATE_LSB = 9;
  localparam int CPI_RATE_W   = 3;
  localparam int CPI_DUTY_LSB = 1;
  localparam int CPI_DUTY_W   = 8;
  localparam int CPI_PEN_BIT  = 0;

  // Limit register fields
  localparam int CPI_PEAK_LSB = 14;
  localparam int CPI_PEAK_W   = 2;
  localparam int CPI_METH_LSB = 12;
  localparam int CPI_METH_W   = 2;
  localparam int CPI_HEAT_BIT = 11;
  localparam int CPI_WIN_LSB  = 8;
  localparam int CPI_WIN_W    = 3;
  localparam int CPI_SURG_LSB = 4;
  localparam int CPI_SURG_W   = 4;
  localparam int CPI_STDY_LSB = 0;
  localparam int CPI_STDY_W   = 4;

  // Load charging methods
  typedef enum logic [1:0] {
    CPI_CHG_NONE  = 2'h0,
    CPI_CHG_RAMP  = 2'h1,
    CPI_CHG_REG   = 2'h2,
    CPI_CHG_PULSE = 2'h3
  } cpi_chg_t;

  // Surge sequence, Gray coded
  typedef enum logic [1:0] {
    CPI_ST_OFF    = 2'b00,
    CPI_ST_SURGE  = 2'b01,
    CPI_ST_STEADY = 2'b11
  } cpi_state_t;

  // Clock and timing
  localparam longint CPI_CLK_HZ        = 64'd250_000_000;
  localparam int     CPI_CLK_PERIOD_NS = 4;
  localparam int     CPI_MIN_ON_NS     = 200_000;
  localparam int     CPI_MIN_ON_CYC    = (CPI_MIN_ON_NS + CPI_CLK_PERIOD_NS - 1) / CPI_CLK_PERIOD_NS;
  localparam int     CPI_MS_NS         = 1_000_000;
  localparam int     CPI_CYC_PER_MS    = CPI_MS_NS / CPI_CLK_PERIOD_NS;

  // Pulse rates in tenths of a hertz, codes 0 to 7
  localparam longint CPI_DHZ_0 = 64'd8;
  localparam longint CPI_DHZ_1 = 64'd34;
  localparam longint CPI_DHZ_2 = 64'd138;
  localparam longint CPI_DHZ_3 = 64'd1110;
  localparam longint CPI_DHZ_4 = 64'd2210;
  localparam longint CPI_DHZ_5 = 64'd4430;
  localparam longint CPI_DHZ_6 = 64'd8850;
  localparam longint CPI_DHZ_7 = 64'd17700;
  localparam longint CPI_DHZ_SCALE = 64'd10;

  // Surge window lengths in milliseconds, codes 0 to 7
  localparam logic [7:0] CPI_WIN_MS_0 = 8'h00;
  localparam logic [7:0] CPI_WIN_MS_1 = 8'h02;
  localparam logic [7:0] CPI_WIN_MS_2 = 8'h04;
  localparam logic [7:0] CPI_WIN_MS_3 = 8'h06;
  localparam logic [7:0] CPI_WIN_MS_4 = 8'h0A;
  localparam logic [7:0] CPI_WIN_MS_5 = 8'h14;
  localparam logic [7:0] CPI_WIN_MS_6 = 8'h32;
  localparam logic [7:0] CPI_WIN_MS_7 = 8'h64;

  // Highest supported trip code (70 A)
  localparam logic [3:0] CPI_TRIP_MAX = 4'hC;
endpackage : cpi_pkg

// ==== hw/cpi_channel_ctrl.sv ====
// Channel pulse width, surge window and trip level selection for one switch channel
// Summary of operation
// - Bits 11-9 pick one of eight pulse rates
// - Bits 8-1 set on-time in 1/256 steps
// - Pulse mode needs on-time above 200us, else error
// - Output follows request, or pulses while request on
// - Pulse method: bits 15-14 pick peak trip
// - Bits 13-12 choose the load charging method
// - No pulsing or heat guard during active charging
// - Bit 11 enables wire heat guard, settable early
// - Heat accumulation starts after charging period ends
// - Bits 10-8 pick surge window length
// - Method none: bits 7-4 are surge trip level
// - Regulation method: level from table divided by five
// - Ramp method: bits 7-4 pick supported ramp rates
// - Pulse method: bits 7-4 are pulse parameters
// - After window, steady trip level from bits 3-0
`timescale 1ns/1ps
`default_nettype none
module cpi_channel_ctrl #(
  parameter int MIN_ON_CYC = cpi_pkg::CPI_MIN_ON_CYC,
  parameter int CYC_PER_MS = cpi_pkg::CPI_CYC_PER_MS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        switch_on_request,
  output logic             ch1_out_on,
  output logic             ch1_pulse_active,
  output logic             ch1_pulse_err,
  output logic             ch1_surge_active,
  output logic [1:0]       ch1_charge_method,
  output logic [3:0]       ch1_charge_param,
  output logic             ch1_ramp_code_ok,
  output logic [1:0]       ch1_peak_trip,
  output logic [3:0]       ch1_trip_level,
  output logic             ch1_trip_div5,
  output logic             ch1_wire_heat_run
);
  import cpi_pkg::*;

  logic [15:0] pulse_cfg_q;
  logic [15:0] limit_cfg_q;
  cpi_state_t  state_q;
  logic [31:0] win_cnt_q;
  logic [31:0] pwm_cnt_q;
  logic        req_q;
  logic        out_q;

  logic [2:0]  rate_sel;
  logic [7:0]  on_frac;
  logic        pulse_on_bit;
  cpi_chg_t    method;
  logic [31:0] period_cyc;
  logic [31:0] on_cyc;
  logic        on_ok;
  logic        charging;
  logic        pwm_run;
  logic        out_d;

  // Period in clock cycles for a rate code
  function automatic logic [31:0] rate_period(input logic [2:0] code);
    longint dhz;
    case (code)
      3'h0:    dhz = CPI_DHZ_0;
      3'h1:    dhz = CPI_DHZ_1;
      3'h2:    dhz = CPI_DHZ_2;
      3'h3:    dhz = CPI_DHZ_3;
      3'h4:    dhz = CPI_DHZ_4;
      3'h5:    dhz = CPI_DHZ_5;
      3'h6:    dhz = CPI_DHZ_6;
      default: dhz = CPI_DHZ_7;
    endcase
    return 32'((CPI_CLK_HZ * CPI_DHZ_SCALE) / dhz);
  endfunction : rate_period

  // Window length in milliseconds for a window code
  function automatic logic [7:0] window_ms(input logic [2:0] code);
    case (code)
      3'h0:    return CPI_WIN_MS_0;
      3'h1:    return CPI_WIN_MS_1;
      3'h2:    return CPI_WIN_MS_2;
      3'h3:    return CPI_WIN_MS_3;
      3'h4:    return CPI_WIN_MS_4;
      3'h5:    return CPI_WIN_MS_5;
      3'h6:    return CPI_WIN_MS_6;
      default: return CPI_WIN_MS_7;
    endcase
  endfunction : window_ms

  // Field extraction
  assign rate_sel     = pulse_cfg_q[CPI_RATE_LSB +: CPI_RATE_W];
  assign on_frac      = pulse_cfg_q[CPI_DUTY_LSB +: CPI_DUTY_W];
  assign pulse_on_bit = pulse_cfg_q[CPI_PEN_BIT];
  assign method       = cpi_chg_t'(limit_cfg_q[CPI_METH_LSB +: CPI_METH_W]);

  // On-time scales linearly with the fraction in 1/256 steps
  assign period_cyc = rate_period(rate_sel);
  assign on_cyc     = 32'((40'(period_cyc) * 40'(on_frac)) >> CPI_DUTY_W);
  assign on_ok      = on_cyc > 32'(MIN_ON_CYC);

  // Charging counts only while the surge window runs with a method chosen
  assign charging = (state_q == CPI_ST_SURGE) && (method != CPI_CHG_NONE);

  // Refused enables leave the output under direct request control
  assign pwm_run = pulse_on_bit && on_ok && (method == CPI_CHG_NONE)
                   && !charging;

  // Direct follow or pulsing, both gated by the request
  assign out_d = !switch_on_request ? 1'b0 :
                 !pwm_run ? 1'b1 : (pwm_cnt_q < on_cyc);

  // Register writes; reserved high nibble of the pulse register stays zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulse_cfg_q <= CPI_PULSE_RESET;
      limit_cfg_q <= CPI_LIMIT_RESET;
    end else if (reg_wr_en) begin
      if (reg_addr == CPI_PULSE_ADDR) begin
        pulse_cfg_q <= reg_wdata & CPI_PULSE_WMASK;
      end
      if (reg_addr == CPI_LIMIT_ADDR) begin
        limit_cfg_q <= reg_wdata & CPI_LIMIT_WMASK;
      end
    end
  end

  // Registered read answer, unmapped addresses read zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd_en;
      if (reg_rd_en) begin
        case (reg_addr)
          CPI_PULSE_ADDR: reg_rdata <= pulse_cfg_q;
          CPI_LIMIT_ADDR: reg_rdata <= limit_cfg_q;
          default:        reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Surge window starts at each turn-on request edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q   <= CPI_ST_OFF;
      win_cnt_q <= 32'h0000_0000;
      req_q     <= 1'b0;
    end else begin
      req_q <= switch_on_request;
      case (state_q)
        CPI_ST_OFF: begin
          if (switch_on_request && !req_q) begin
            state_q   <= CPI_ST_SURGE;
            win_cnt_q <= 32'(window_ms(limit_cfg_q[CPI_WIN_LSB +: CPI_WIN_W]))
                         * 32'(CYC_PER_MS);
          end
        end
        CPI_ST_SURGE: begin
          if (!switch_on_request) begin
            state_q <= CPI_ST_OFF;
          end else if (win_cnt_q == 32'h0000_0000) begin
            state_q <= CPI_ST_STEADY;
          end else begin
            win_cnt_q <= win_cnt_q - 32'h0000_0001;
          end
        end
        CPI_ST_STEADY: begin
          if (!switch_on_request) begin
            state_q <= CPI_ST_OFF;
          end
        end
        default: state_q <= CPI_ST_OFF;
      endcase
    end
  end

  // Period counter; held at zero when not pulsing so each burst starts on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwm_cnt_q <= 32'h0000_0000;
    end else if (!pwm_run || !switch_on_request) begin
      pwm_cnt_q <= 32'h0000_0000;
    end else if (pwm_cnt_q >= period_cyc - 32'h0000_0001) begin
      pwm_cnt_q <= 32'h0000_0000;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 32'h0000_0001;
    end
  end

  // Output and status flags from flip-flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_q             <= 1'b0;
      ch1_pulse_active  <= 1'b0;
      ch1_pulse_err     <= 1'b0;
      ch1_wire_heat_run <= 1'b0;
    end else begin
      out_q             <= out_d;
      ch1_pulse_active  <= pwm_run && switch_on_request;
      ch1_pulse_err     <= pulse_on_bit && !on_ok;
      // Heat accumulation waits out the charging period
      ch1_wire_heat_run <= limit_cfg_q[CPI_HEAT_BIT] && switch_on_request
                           && !charging && (state_q != CPI_ST_OFF);
    end
  end
  assign ch1_out_on = out_q;

  // Trip level and charging controls to the analog side, registered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ch1_surge_active  <= 1'b0;
      ch1_charge_method <= CPI_CHG_NONE;
      ch1_charge_param  <= 4'h0;
      ch1_ramp_code_ok  <= 1'b0;
      ch1_peak_trip     <= 2'h0;
      ch1_trip_level    <= 4'h0;
      ch1_trip_div5     <= 1'b0;
    end else begin
      ch1_surge_active  <= state_q == CPI_ST_SURGE;
      ch1_charge_method <= charging ? method : CPI_CHG_NONE;
      ch1_charge_param  <= charging ? limit_cfg_q[CPI_SURG_LSB +: CPI_SURG_W]
                                    : 4'h0;
      case (limit_cfg_q[CPI_SURG_LSB +: CPI_SURG_W])
        4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC:
                 ch1_ramp_code_ok <= charging && method == CPI_CHG_RAMP;
        default: ch1_ramp_code_ok <= 1'b0;
      endcase
      ch1_peak_trip <= (charging && method == CPI_CHG_PULSE)
                       ? limit_cfg_q[CPI_PEAK_LSB +: CPI_PEAK_W] : 2'h0;
      ch1_trip_div5 <= charging && method == CPI_CHG_REG;
      if (state_q == CPI_ST_SURGE && (method == CPI_CHG_NONE || method == CPI_CHG_REG)) begin
        ch1_trip_level <= limit_cfg_q[CPI_SURG_LSB +: CPI_SURG_W];
      end else begin
        ch1_trip_level <= limit_cfg_q[CPI_STDY_LSB +: CPI_STDY_W];
      end
    end
  end
endmodule : cpi_channel_ctrl
`default_nettype wire

// ==== test/cpi_channel_ctrl_properties.sv ====
// Port-level properties of the channel pulse and surge control block
`timescale 1ns/1ps
`default_nettype none
module cpi_channel_ctrl_properties (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       reg_rd_en,
  input wire logic       reg_rvalid,
  input wire logic       switch_on_request,
  input wire logic       ch1_out_on,
  input wire logic       ch1_pulse_active,
  input wire logic       ch1_pulse_err,
  input wire logic       ch1_surge_active,
  input wire logic [1:0] ch1_charge_method,
  input wire logic [3:0] ch1_charge_param,
  input wire logic       ch1_ramp_code_ok,
  input wire logic [1:0] ch1_peak_trip,
  input wire logic       ch1_trip_div5,
  input wire logic       ch1_wire_heat_run
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  read_answer_a: assert property (reg_rvalid == $past(reg_rd_en))
    else $error("read answer not one cycle after strobe");
  out_off_a: assert property (!switch_on_request |=> !ch1_out_on)
    else $error("output on without request");
  out_follow_a: assert property (!ch1_pulse_active && switch_on_request |=> ch1_out_on)
    else $error("output not following request");
  surge_start_a: assert property ($rose(ch1_surge_active) |-> $past(switch_on_request, 2))
    else $error("surge window without request");
  surge_abort_a: assert property (ch1_surge_active && !switch_on_request |-> ##2 !ch1_surge_active)
    else $error("surge window kept after request drop");
  charge_no_pulse_a: assert property (ch1_charge_method != 2'h0 |-> !ch1_pulse_active)
    else $error("pulsing while charging");
  heat_hold_a: assert property (ch1_charge_method != 2'h0 |-> !ch1_wire_heat_run)
    else $error("heat accumulation while charging");
  div5_sel_a: assert property (ch1_trip_div5 == (ch1_charge_method == 2'h2))
    else $error("divide by five flag wrong");
  peak_sel_a: assert property (ch1_charge_method != 2'h3 |-> ch1_peak_trip == 2'h0)
    else $error("peak trip outside pulse method");
  ramp_code_a: assert property (ch1_ramp_code_ok |-> ch1_charge_method == 2'h1 && ch1_charge_param inside {4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC})
    else $error("ramp code accepted wrongly");
  err_excl_a: assert property (ch1_pulse_err |-> !ch1_pulse_active)
    else $error("pulsing despite short on-time");
  // Main scenarios reached
  cover property (ch1_pulse_active);
  cover property (ch1_trip_div5);
  cover property (ch1_pulse_err);
endmodule : cpi_channel_ctrl_properties
bind cpi_channel_ctrl cpi_channel_ctrl_properties props (.sys_clk, .rst, .reg_rd_en, .reg_rvalid,
  .switch_on_request, .ch1_out_on, .ch1_pulse_active, .ch1_pulse_err, .ch1_surge_active,
  .ch1_charge_method, .ch1_charge_param, .ch1_ramp_code_ok, .ch1_peak_trip, .ch1_trip_div5,
  .ch1_wire_heat_run);
`default_nettype wire

// ==== test/cpi_host_model.sv ====
// Behavioural register host driving the parallel register port
`timescale 1ns/1ps
`default_nettype none
module cpi_host_model (
  input  wire logic        sys_clk,
  output logic             reg_wr_en,
  output logic             reg_rd_en,
  output logic [5:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  // Idle at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 6'h00;
    reg_wdata = 16'h0000;
  end
  // One-cycle strobe; released lines show inverted junk, not stale data
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // Answer expected one cycle after the strobe edge
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    #1;
    d = reg_rvalid ? reg_rdata : 16'hXXXX;
  endtask : rd
endmodule : cpi_host_model
`default_nettype wire

// ==== test/tb_channel_pwm_and_inrush_control.sv ====
// Self-checking bench for the channel pulse and surge control block
`timescale 1ns/1ps
`default_nettype none
module tb_channel_pwm_and_inrush_control;
  import cpi_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic switch_on_request = 1'b0;
  logic reg_wr_en, reg_rd_en, reg_rvalid, ch1_out_on, ch1_pulse_active, ch1_pulse_err;
  logic ch1_surge_active, ch1_ramp_code_ok, ch1_trip_div5, ch1_wire_heat_run;
  logic [5:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [1:0] ch1_charge_method, ch1_peak_trip;
  logic [3:0] ch1_charge_param, ch1_trip_level;
  logic [19:0] st;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // Flags byte, then method, peak, param, trip level
  assign st = {ch1_out_on, ch1_pulse_active, ch1_pulse_err, ch1_surge_active, ch1_wire_heat_run,
               ch1_trip_div5, ch1_ramp_code_ok, 1'b0, ch1_charge_method, ch1_peak_trip,
               ch1_charge_param, ch1_trip_level};
  // Short counts keep the run small
  cpi_channel_ctrl #(.MIN_ON_CYC(20), .CYC_PER_MS(10)) i_cpi_channel_ctrl (.sys_clk, .rst,
    .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .switch_on_request,
    .ch1_out_on, .ch1_pulse_active, .ch1_pulse_err, .ch1_surge_active, .ch1_charge_method,
    .ch1_charge_param, .ch1_ramp_code_ok, .ch1_peak_trip, .ch1_trip_level, .ch1_trip_div5,
    .ch1_wire_heat_run);
  cpi_host_model host (.sys_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid);
  always #2 sys_clk = ~sys_clk;
  task automatic report_and_stop();
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [19:0] seen, input logic [19:0] exp,
                       input logic [19:0] msk = 20'hFFFFF);
    comparisons++;
    if ((seen & msk) !== (exp & msk)) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Request changes at an edge, outputs judged once settled
  task automatic req_step(input logic v, input int n);
    @(posedge sys_clk);
    switch_on_request <= v;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : req_step
  // Ceiling well above the roughly 700 cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    host.rd(CPI_LIMIT_ADDR, d);
    check({4'h0, d}, {4'h0, CPI_LIMIT_RESET});
    host.rd(CPI_PULSE_ADDR, d);
    check({4'h0, d}, {4'h0, CPI_PULSE_RESET});
    host.rd(6'h10, d);
    check({4'h0, d}, 20'h00000);
    host.wr(CPI_PULSE_ADDR, 16'hFFFF);
    host.rd(CPI_PULSE_ADDR, d);
    check({4'h0, d}, 20'h00FFF);
    host.wr(CPI_PULSE_ADDR, 16'h0000);
    // No charging: surge level, then steady level, heat guard running
    host.wr(CPI_LIMIT_ADDR, 16'h0959);
    req_step(1'b1, 3);
    check(st, 20'h90005, 20'hF70FF);
    repeat (30) @(posedge sys_clk);
    #1;
    check(st, 20'h88009);
    // Fastest rate, one step of on-time: about 551 cycles on, then off
    host.wr(CPI_PULSE_ADDR, 16'h0E03);
    repeat (500) @(posedge sys_clk);
    #1;
    check(st, 20'hC8009);
    repeat (100) @(posedge sys_clk);
    #1;
    check(st, 20'h48009);
    host.wr(CPI_PULSE_ADDR, 16'h0FFF);
    repeat (3) @(posedge sys_clk);
    #1;
    check(st, 20'hC8009);
    host.wr(CPI_PULSE_ADDR, 16'h0E01);
    repeat (3) @(posedge sys_clk);
    #1;
    check(st, 20'hA8009);
    req_step(1'b0, 3);
    check(st, 20'h00009, 20'hDFFFF);
    // Each charging method with pulse enable requested
    for (int m = 1; m < 4; m++) begin
      host.wr(CPI_LIMIT_ADDR, {2'h2, 2'(m), 1'b1, 3'h7, 4'hC, 4'h9});
      host.wr(CPI_PULSE_ADDR, 16'h0FFF);
      req_step(1'b1, 3);
      check(st, {8'h90 | ((m == 2) ? 8'h04 : 8'h00) | ((m == 1) ? 8'h02 : 8'h00), 2'(m),
                 (m == 3) ? 2'h2 : 2'h0, 4'hC, (m == 2) ? 4'hC : 4'h9});
      req_step(1'b0, 3);
    end
    report_and_stop();
  end
endmodule : tb_channel_pwm_and_inrush_control
`default_nettype wire
